// *** bench/caw_watchdog_tb_top.sv ***
// Self-checking testbench for the counter-array watchdog block
`timescale 1ns/1ns
`default_nettype none

module caw_watchdog_tb_top;
	logic mclk, resetn, awvalid, wvalid, bready, arvalid, rready;
	logic idleMode, extClkPin, awready, wready, bvalid, arready, rvalid;
	logic ch4WatchdogMode, systemReset;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [33:0] rdQ[$];
	string nmQ[$];
	logic [1:0] bQ[$];
	logic [33:0] rdExp;
	int badCount, totalChecks, cycles, span;

	// ****************************************************
	// Clock, design and timeout
	// ****************************************************
	always #20 mclk = ~mclk;

	caw_watchdog dut_u (.mclk(mclk), .resetn(resetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .idleMode(idleMode), .extClkPin(extClkPin),
		.ch4WatchdogMode(ch4WatchdogMode), .systemReset(systemReset));

	// Whole run needs under two thousand cycles; this ceiling catches a hang
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			badCount++;
			$display("CHECK FAILED timeout expected end seen hang");
			stopTest();
		end
	end

	// ****************************************************
	// Compare tasks and closing report
	// ****************************************************
	task automatic chkWord(string what, logic [31:0] e, logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			badCount++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chkWord

	task automatic chkResp(string what, logic [1:0] e, logic [1:0] g);
		totalChecks++;
		if (g !== e) begin
			badCount++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chkResp

	task automatic chkBit(string what, logic e, logic g);
		totalChecks++;
		if (g !== e) begin
			badCount++;
			$display("CHECK FAILED %s expected %b seen %b", what, e, g);
		end
	endtask : chkBit

	task automatic chkSpan(string what, int lo, int hi, int g);
		totalChecks++;
		if (g < lo || g > hi) begin
			badCount++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, g);
		end
	endtask : chkSpan

	task automatic stopTest();
		$display("Checks made %0d, mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stopTest

	// ****************************************************
	// Monitor: each answer is matched against the oldest note
	// ****************************************************
	always @(posedge mclk) begin
		if (rvalid === 1'b1 && rready === 1'b1 && rdQ.size() > 0) begin
			rdExp = rdQ.pop_front();
			chkWord(nmQ[0], rdExp[31:0], rdata);
			chkResp(nmQ.pop_front(), rdExp[33:32], rresp);
		end
		if (bvalid === 1'b1 && bready === 1'b1 && bQ.size() > 0)
			chkResp("bresp", bQ.pop_front(), bresp);
	end

	// ****************************************************
	// Bus master tasks
	// ****************************************************
	// Address and data offered together, each released once taken
	task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] resp);
		bQ.push_back(resp);
		@(posedge mclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Only the bench ceiling ends a wait for the answer
		do begin
			@(posedge mclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(string what, logic [7:0] a, logic [31:0] e,
		logic [1:0] resp);
		rdQ.push_back({resp, e});
		nmQ.push_back(what);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask : rd

	// Pin pulses long enough to pass the three-stage filter
	task automatic pinPulses(int k);
		repeat (k) begin
			@(posedge mclk);
			extClkPin <= 1'b1;
			repeat (4) @(posedge mclk);
			extClkPin <= 1'b0;
			repeat (3) @(posedge mclk);
		end
	endtask : pinPulses

	task automatic endTest(string what);
		@(posedge mclk);
		$display("Test done: %s", what);
	endtask : endTest

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h00000000;
		wstrb = 4'hF;
		idleMode = 1'b0;
		extClkPin = 1'b0;
		badCount = 0;
		totalChecks = 0;
		cycles = 0;
		void'($urandom(32'h098D4800));
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;

		// Supervision is live straight out of reset
		rd("mode", caw_pkg::ADDR_MODE, 32'h00000001, caw_pkg::RESP_OKAY);
		chkBit("wdmode", 1'b1, ch4WatchdogMode);
		endTest("reset state");

		// Refresh loads counter high plus offset, written value lost
		wr(caw_pkg::ADDR_CH4L, 8'h03, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_CH4H, 8'($urandom()), caw_pkg::RESP_OKAY);
		rd("ch4h", caw_pkg::ADDR_CH4H, 32'h00000003, caw_pkg::RESP_OKAY);
		endTest("refresh");

		// Locked controls while supervising
		wr(caw_pkg::ADDR_CNTH, 8'($urandom()) | 8'h01, caw_pkg::RESP_OKAY);
		rd("cnth", caw_pkg::ADDR_CNTH, 32'h00000000, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_CTRL, 8'h00, caw_pkg::RESP_OKAY);
		rd("ctrl", caw_pkg::ADDR_CTRL, 32'h00000002, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_MODE, 8'h9D, caw_pkg::RESP_OKAY);
		rd("mode", caw_pkg::ADDR_MODE, 32'h00000001, caw_pkg::RESP_OKAY);
		chkBit("wdmode", 1'b1, ch4WatchdogMode);
		wr(caw_pkg::ADDR_CH4M, 8'h49, caw_pkg::RESP_OKAY);
		rd("ch4m", caw_pkg::ADDR_CH4M, 32'h00000000, caw_pkg::RESP_OKAY);
		// Cleared byte lane 0 must leave the offset alone
		wstrb <= 4'hE;
		wr(caw_pkg::ADDR_CH4L, 8'h55, caw_pkg::RESP_OKAY);
		wstrb <= 4'hF;
		rd("ch4l", caw_pkg::ADDR_CH4L, 32'h00000003, caw_pkg::RESP_OKAY);
		wr(8'h40, 8'h11, caw_pkg::RESP_SLVERR);
		rd("unmapped", 8'h40, 32'h00000000, caw_pkg::RESP_SLVERR);
		endTest("locked controls");

		// Disable, preset the stopped counter, then re-arm on mclk/4
		wr(caw_pkg::ADDR_MODE, 8'h00, caw_pkg::RESP_OKAY);
		chkBit("wdmode", 1'b0, ch4WatchdogMode);
		wr(caw_pkg::ADDR_MODE, 8'h04, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_CNTL, 8'hF0, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_CNTH, 8'h10, caw_pkg::RESP_OKAY);
		rd("cnth", caw_pkg::ADDR_CNTH, 32'h00000010, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_CH4M, 8'h21, caw_pkg::RESP_OKAY);
		rd("ch4m", caw_pkg::ADDR_CH4M, 32'h00000021, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_CH4L, 8'h02, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_MODE, 8'h05, caw_pkg::RESP_OKAY);
		rd("mode", caw_pkg::ADDR_MODE, 32'h00000005, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_CH4H, 8'h77, caw_pkg::RESP_OKAY);
		span = 0;
		rd("ch4h", caw_pkg::ADDR_CH4H, 32'h00000012, caw_pkg::RESP_OKAY);
		// Two low-byte overflows at four cycles per tick before the hit
		while (systemReset !== 1'b1 && span < 2000) begin
			@(posedge mclk);
			span++;
		end
		chkSpan("reset delay", 1020, 1120, span);
		endTest("watchdog expiry");

		// Software run on the pin clock, then idle suspend stops it
		wr(caw_pkg::ADDR_MODE, 8'h00, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_MODE, 8'h08, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_CNTL, 8'h00, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_CTRL, 8'h01, caw_pkg::RESP_OKAY);
		pinPulses(5);
		rd("cntl", caw_pkg::ADDR_CNTL, 32'h00000005, caw_pkg::RESP_OKAY);
		rd("ctrl", caw_pkg::ADDR_CTRL, 32'h00000003, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_MODE, 8'h88, caw_pkg::RESP_OKAY);
		idleMode <= 1'b1;
		pinPulses(3);
		rd("cntl", caw_pkg::ADDR_CNTL, 32'h00000005, caw_pkg::RESP_OKAY);
		rd("ctrl", caw_pkg::ADDR_CTRL, 32'h00000001, caw_pkg::RESP_OKAY);
		idleMode <= 1'b0;
		wr(caw_pkg::ADDR_MODE, 8'h05, caw_pkg::RESP_OKAY);
		endTest("pin clock and idle");

		// Lock keeps supervision on until the next reset
		wr(caw_pkg::ADDR_MODE, 8'h02, caw_pkg::RESP_OKAY);
		wr(caw_pkg::ADDR_MODE, 8'h00, caw_pkg::RESP_OKAY);
		rd("mode", caw_pkg::ADDR_MODE, 32'h00000007, caw_pkg::RESP_OKAY);
		chkBit("wdmode", 1'b1, ch4WatchdogMode);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		rd("mode", caw_pkg::ADDR_MODE, 32'h00000001, caw_pkg::RESP_OKAY);
		endTest("lock and second reset");
		stopTest();
	end
endmodule : caw_watchdog_tb_top

`default_nettype wire

// *** core/caw_counter.sv ***
// Shared 16-bit up-counter with byte loads and low-byte overflow
`timescale 1ns/1ns
`default_nettype none

module caw_counter (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic tick,
	input wire logic run,
	input wire logic loadLow,
	input wire logic loadHigh,
	input wire logic [7:0] loadData,
	output logic [15:0] count,
	output logic lowOverflow
);

	logic [15:0] next_count;

	// ****************************************************
	// Count: loads win, otherwise one step per running tick
	// ****************************************************
	always_comb begin
		next_count = count;
		if (loadLow) begin
			next_count = {count[15:8], loadData};
		end else if (loadHigh) begin
			next_count = {loadData, count[7:0]};
		end else if (run && tick) begin
			next_count = count + caw_pkg::COUNT_STEP; // R17
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			count <= caw_pkg::COUNT_ZERO;
		end else begin
			count <= next_count;
		end
	end

	// Carry out of the low byte, one cycle wide
	assign lowOverflow = run & tick & ~loadLow & ~loadHigh &
		(count[7:0] == caw_pkg::LOW_FULL); // R16

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_high_carry: assert property (lowOverflow |=> // R17
		count[15:8] == $past(count[15:8]) + 8'h01 && count[7:0] == 8'h00)
		else $error("low byte overflow did not step the high byte");

endmodule : caw_counter

`default_nettype wire

// *** core/caw_pkg.sv ***
// Package of offsets, field positions and constants for the counter watchdog
package caw_pkg;

	// ****************************************************
	// Register byte addresses on the AXI4-Lite bus
	// ****************************************************
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_CNTL = 8'h08;
	localparam logic [7:0] ADDR_CNTH = 8'h0C;
	localparam logic [7:0] ADDR_CH4L = 8'h10;
	localparam logic [7:0] ADDR_CH4H = 8'h14;
	localparam logic [7:0] ADDR_CH4M = 8'h18;

	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int MODE_EN = 0;
	localparam int MODE_LOCK = 1;
	localparam int MODE_CPS_LO = 2;
	localparam int MODE_CPS_HI = 4;
	localparam int MODE_COUNTER_IDLE_SUSPEND = 7;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_ACTIVE = 1;

	// ****************************************************
	// Reset values, count step and low-byte full value
	// ****************************************************
	localparam logic [7:0] MODE_RESET = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_STEP = 16'h0001;
	localparam logic [7:0] LOW_FULL = 8'hFF;

	// ****************************************************
	// Counter clock selections and prescale terminals
	// ****************************************************
	localparam logic [2:0] CPS_DIV12 = 3'h0;
	localparam logic [2:0] CPS_DIV4 = 3'h1;
	localparam logic [2:0] CPS_EXT = 3'h2;
	localparam logic [3:0] DIV_SLOW_TERM = 4'hB;
	localparam logic [3:0] DIV_FAST_TERM = 4'h3;
	localparam logic [3:0] DIV_ZERO = 4'h0;
	localparam logic [3:0] DIV_STEP = 4'h1;
	localparam int LOW_SPAN = 256;

	// ****************************************************
	// Bus responses and read channel states
	// ****************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic {RD_IDLE, RD_RESP} caw_rd_t;

endpackage : caw_pkg

// *** core/caw_tick_gen.sv ***
// Counter clock tick generator: prescaler and synchronised external clock pin
`timescale 1ns/1ns
`default_nettype none

module caw_tick_gen (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [2:0] clockSelect,
	input wire logic extClkPin,
	output logic tick
);

	logic [2:0] pinSync;
	logic pinLevel;
	logic [3:0] divCount;
	logic [2:0] next_pinSync;
	logic next_pinLevel;
	logic [3:0] next_divCount;
	logic [3:0] divTerm;
	logic pinRise;

	// ****************************************************
	// Next state: the pin counts only once stages two and three agree
	// ****************************************************
	always_comb begin
		next_pinSync = {pinSync[1:0], extClkPin};
		next_pinLevel = pinLevel;
		if (pinSync[2] == pinSync[1]) begin
			next_pinLevel = pinSync[2];
		end
		divTerm = (clockSelect == caw_pkg::CPS_DIV4) ?
			caw_pkg::DIV_FAST_TERM : caw_pkg::DIV_SLOW_TERM;
		if (divCount >= divTerm) begin
			next_divCount = caw_pkg::DIV_ZERO;
		end else begin
			next_divCount = divCount + caw_pkg::DIV_STEP;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pinSync <= 3'h0;
			pinLevel <= 1'b0;
			divCount <= caw_pkg::DIV_ZERO;
		end else begin
			pinSync <= next_pinSync;
			pinLevel <= next_pinLevel;
			divCount <= next_divCount;
		end
	end

	// Tick selection; any unlisted code runs at the full clock rate
	assign pinRise = next_pinLevel & ~pinLevel;
	always_comb begin
		case (clockSelect)
			caw_pkg::CPS_DIV12, caw_pkg::CPS_DIV4: tick = (divCount >= divTerm);
			caw_pkg::CPS_EXT: tick = pinRise;
			default: tick = 1'b1;
		endcase
	end

endmodule : caw_tick_gen

`default_nettype wire

// *** core/caw_watchdog.sv ***
// Counter-array watchdog top with AXI4-Lite register slave
// Function
// R1: Supervision is enabled when the block leaves any reset.
// R2: Enable or lock bit set makes channel 4 the supervisory timer.
// R3: Channel high byte is compared with the shared counter high byte.
// R4: Channel low byte holds the reload offset used on each refresh.
// R5: Shared counter runs whatever the run bit while supervising.
// R6: Writes to both counter bytes are ignored while supervising.
// R7: The three clock-select bits are frozen while supervising.
// R8: The idle-suspend bit is frozen while supervising.
// R9: Channel 4 is forced into watchdog operation while supervising.
// R10: Channel 4 mode register writes are blocked while supervising.
// R11: Run-bit writes leave the counter running while supervising.
// R12: Run bit reads zero when software never set it, even if running.
// R13: A compare match while supervising raises a system reset.
// R14: A channel high write reloads counter high plus offset.
// R15: The offset counts low-byte overflows before reset.
// R16: First overflow after refresh takes up to 256 counter clocks.
// R17: Counter is 16-bit, low overflow steps high; compare each tick.
`timescale 1ns/1ns
`default_nettype none

module caw_watchdog (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic idleMode,
	input wire logic extClkPin,
	output logic ch4WatchdogMode,
	output logic systemReset
);

	// ****************************************************
	// Declarations
	// ****************************************************
	logic awHeld;
	logic [7:0] awAddrHeld;
	logic wHeld;
	logic [7:0] wByteHeld;
	logic wLaneHeld;
	logic [1:0] next_bresp;
	logic next_bvalid;
	logic next_awHeld;
	logic [7:0] next_awAddrHeld;
	logic next_wHeld;
	logic [7:0] next_wByteHeld;
	logic next_wLaneHeld;
	caw_pkg::caw_rd_t rdState;
	caw_pkg::caw_rd_t next_rdState;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic doWrite;
	logic wrMapped;
	logic wrMode, wrCtrl, wrCntl, wrCnth, wrCh4l, wrCh4h, wrCh4m;
	logic [7:0] mode;
	logic runControl;
	logic [7:0] ch4Low;
	logic [7:0] ch4High;
	logic [7:0] ch4Mode;
	logic [7:0] next_mode;
	logic next_runControl;
	logic [7:0] next_ch4Low;
	logic [7:0] next_ch4High;
	logic [7:0] next_ch4Mode;
	logic next_systemReset;
	logic supervising;
	logic counterRun;
	logic tick;
	logic [15:0] count;
	logic [7:0] cntHigh;
	logic [7:0] refreshSum;
	logic lowOverflow;
	logic compareHit;

	// ****************************************************
	// Write address and data channels, taken in either order
	// ****************************************************
	assign awready = ~awHeld & ~bvalid;
	assign wready = ~wHeld & ~bvalid;
	assign doWrite = awHeld & wHeld & ~bvalid;

	always_comb begin
		next_awHeld = awHeld;
		next_awAddrHeld = awAddrHeld;
		next_wHeld = wHeld;
		next_wByteHeld = wByteHeld;
		next_wLaneHeld = wLaneHeld;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (awvalid && awready) begin
			next_awHeld = 1'b1;
			next_awAddrHeld = awaddr;
		end
		if (wvalid && wready) begin
			next_wHeld = 1'b1;
			next_wByteHeld = wdata[7:0];
			next_wLaneHeld = wstrb[0];
		end
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wrMapped ? caw_pkg::RESP_OKAY : caw_pkg::RESP_SLVERR;
		end else if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			awHeld <= 1'b0;
			awAddrHeld <= caw_pkg::BYTE_ZERO;
			wHeld <= 1'b0;
			wByteHeld <= caw_pkg::BYTE_ZERO;
			wLaneHeld <= 1'b0;
			bvalid <= 1'b0;
			bresp <= caw_pkg::RESP_OKAY;
		end else begin
			awHeld <= next_awHeld;
			awAddrHeld <= next_awAddrHeld;
			wHeld <= next_wHeld;
			wByteHeld <= next_wByteHeld;
			wLaneHeld <= next_wLaneHeld;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
		end
	end

	// ****************************************************
	// Write decode; a cleared byte lane 0 stores nothing
	// ****************************************************
	always_comb begin
		wrMapped = 1'b1;
		wrMode = 1'b0;
		wrCtrl = 1'b0;
		wrCntl = 1'b0;
		wrCnth = 1'b0;
		wrCh4l = 1'b0;
		wrCh4h = 1'b0;
		wrCh4m = 1'b0;
		if (awAddrHeld == caw_pkg::ADDR_MODE) begin
			wrMode = doWrite & wLaneHeld;
		end else if (awAddrHeld == caw_pkg::ADDR_CTRL) begin
			wrCtrl = doWrite & wLaneHeld;
		end else if (awAddrHeld == caw_pkg::ADDR_CNTL) begin
			wrCntl = doWrite & wLaneHeld;
		end else if (awAddrHeld == caw_pkg::ADDR_CNTH) begin
			wrCnth = doWrite & wLaneHeld;
		end else if (awAddrHeld == caw_pkg::ADDR_CH4L) begin
			wrCh4l = doWrite & wLaneHeld;
		end else if (awAddrHeld == caw_pkg::ADDR_CH4H) begin
			wrCh4h = doWrite & wLaneHeld;
		end else if (awAddrHeld == caw_pkg::ADDR_CH4M) begin
			wrCh4m = doWrite & wLaneHeld;
		end else begin
			wrMapped = 1'b0;
		end
	end

	// ****************************************************
	// Supervision state and counter control
	// ****************************************************
	assign supervising = mode[caw_pkg::MODE_EN] | mode[caw_pkg::MODE_LOCK]; // R2
	assign ch4WatchdogMode = supervising; // R9
	// Idle suspend only counts when software alone runs the counter
	assign counterRun = supervising | // R5 R11
		(runControl & ~(idleMode & mode[caw_pkg::MODE_COUNTER_IDLE_SUSPEND]));
	assign cntHigh = count[15:8];
	assign refreshSum = cntHigh + ch4Low; // R4 R14
	assign compareHit = supervising & tick & (ch4High == cntHigh); // R3 R13

	caw_tick_gen u_tick (
		.mclk(mclk),
		.resetn(resetn),
		.clockSelect(mode[caw_pkg::MODE_CPS_HI:caw_pkg::MODE_CPS_LO]),
		.extClkPin(extClkPin),
		.tick(tick)
	);

	// Counter byte loads are dropped while supervising
	caw_counter u_counter (
		.mclk(mclk),
		.resetn(resetn),
		.tick(tick),
		.run(counterRun),
		.loadLow(wrCntl & ~supervising), // R6
		.loadHigh(wrCnth & ~supervising), // R6
		.loadData(wByteHeld),
		.count(count),
		.lowOverflow(lowOverflow)
	);

	// ****************************************************
	// Register file next values
	// ****************************************************
	always_comb begin
		next_mode = mode;
		next_runControl = runControl;
		next_ch4Low = ch4Low;
		next_ch4High = ch4High;
		next_ch4Mode = ch4Mode;
		next_systemReset = compareHit; // R13
		if (wrMode) begin
			// Lock is set-only; while locked the enable bit cannot drop
			next_mode[caw_pkg::MODE_LOCK] = mode[caw_pkg::MODE_LOCK] |
				wByteHeld[caw_pkg::MODE_LOCK];
			next_mode[caw_pkg::MODE_EN] = mode[caw_pkg::MODE_LOCK] |
				wByteHeld[caw_pkg::MODE_EN];
			if (!supervising) begin
				next_mode[caw_pkg::MODE_CPS_HI:caw_pkg::MODE_CPS_LO] = // R7
					wByteHeld[caw_pkg::MODE_CPS_HI:caw_pkg::MODE_CPS_LO];
				next_mode[caw_pkg::MODE_COUNTER_IDLE_SUSPEND] = wByteHeld[caw_pkg::MODE_COUNTER_IDLE_SUSPEND]; // R8
			end
		end
		if (wrCtrl) begin
			// Stored for readback only while supervising
			next_runControl = wByteHeld[caw_pkg::CTRL_RUN]; // R11 R12
		end
		if (wrCh4l) begin
			next_ch4Low = wByteHeld; // R4 R15
		end
		if (wrCh4h) begin
			// Refresh discards the written value
			next_ch4High = supervising ? refreshSum : wByteHeld; // R14 R15
		end
		if (wrCh4m && !supervising) begin
			next_ch4Mode = wByteHeld; // R10
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode <= caw_pkg::MODE_RESET; // R1
			runControl <= 1'b0;
			ch4Low <= caw_pkg::BYTE_ZERO;
			ch4High <= caw_pkg::BYTE_ZERO;
			ch4Mode <= caw_pkg::BYTE_ZERO;
			systemReset <= 1'b0;
		end else begin
			mode <= next_mode;
			runControl <= next_runControl;
			ch4Low <= next_ch4Low;
			ch4High <= next_ch4High;
			ch4Mode <= next_ch4Mode;
			systemReset <= next_systemReset;
		end
	end

	// ****************************************************
	// Read channel: data is latched when the address is taken
	// ****************************************************
	assign arready = (rdState == caw_pkg::RD_IDLE);
	assign rvalid = (rdState == caw_pkg::RD_RESP);

	always_comb begin
		next_rdState = rdState;
		next_rdata = rdata;
		next_rresp = rresp;
		case (rdState)
			caw_pkg::RD_IDLE: begin
				if (arvalid) begin
					next_rdState = caw_pkg::RD_RESP;
					next_rresp = caw_pkg::RESP_OKAY;
					next_rdata = 32'h0000_0000;
					if (araddr == caw_pkg::ADDR_MODE) begin
						next_rdata[7:0] = mode;
					end else if (araddr == caw_pkg::ADDR_CTRL) begin
						next_rdata[caw_pkg::CTRL_RUN] = runControl; // R12
						next_rdata[caw_pkg::CTRL_ACTIVE] = counterRun;
					end else if (araddr == caw_pkg::ADDR_CNTL) begin
						next_rdata[7:0] = count[7:0];
					end else if (araddr == caw_pkg::ADDR_CNTH) begin
						next_rdata[7:0] = cntHigh;
					end else if (araddr == caw_pkg::ADDR_CH4L) begin
						next_rdata[7:0] = ch4Low;
					end else if (araddr == caw_pkg::ADDR_CH4H) begin
						next_rdata[7:0] = ch4High;
					end else if (araddr == caw_pkg::ADDR_CH4M) begin
						next_rdata[7:0] = ch4Mode;
					end else begin
						next_rresp = caw_pkg::RESP_SLVERR;
					end
				end
			end
			caw_pkg::RD_RESP: begin
				if (rready) begin
					next_rdState = caw_pkg::RD_IDLE;
				end
			end
			default: next_rdState = caw_pkg::RD_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdState <= caw_pkg::RD_IDLE;
			rdata <= 32'h0000_0000;
			rresp <= caw_pkg::RESP_OKAY;
		end else begin
			rdState <= next_rdState;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// ****************************************************
	// Assertions and covers
	// ****************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_enabled_after_reset: assert property ($rose(resetn) |-> // R1
		supervising && ch4WatchdogMode)
		else $error("supervision not enabled after reset");
	a_match_resets: assert property (compareHit |=> systemReset) // R13
		else $error("compare match did not raise reset");
	a_reset_has_cause: assert property (systemReset |-> // R3
		$past(supervising) && $past(ch4High) == $past(cntHigh))
		else $error("reset without a compare match");
	a_refresh_load: assert property (wrCh4h && supervising |=> // R14
		ch4High == $past(refreshSum))
		else $error("refresh did not load high plus offset");
	a_forced_run: assert property (supervising && tick |=> // R5
		count == $past(count) + caw_pkg::COUNT_STEP)
		else $error("counter not running while supervising");
	a_count_frozen: assert property (supervising && !tick && // R6
		(wrCntl || wrCnth) |=> $stable(count))
		else $error("counter written while supervising");
	a_mode_frozen: assert property (supervising && wrMode |=> // R7 R8
		$stable(mode[caw_pkg::MODE_CPS_HI:caw_pkg::MODE_CPS_LO]) &&
		$stable(mode[caw_pkg::MODE_COUNTER_IDLE_SUSPEND]))
		else $error("frozen mode bits changed");
	a_ch4_mode_locked: assert property (supervising && wrCh4m |=> // R10
		$stable(ch4Mode))
		else $error("channel 4 mode written while supervising");
	a_run_readback: assert property (arvalid && arready && // R12
		araddr == caw_pkg::ADDR_CTRL && !runControl |=> !rdata[caw_pkg::CTRL_RUN])
		else $error("run bit read as one without software enable");
	a_write_answer: assert property (awvalid && awready && wvalid &&
		wready |=> ##1 bvalid)
		else $error("write response late");

	c_watchdog_reset: cover property (systemReset);
	c_refresh: cover property (wrCh4h && supervising);
	c_overflow_then_hit: cover property (lowOverflow ##[1:300] compareHit);
	c_read_unmapped: cover property (rvalid && rresp == caw_pkg::RESP_SLVERR);

endmodule : caw_watchdog

`default_nettype wire
